// File: common/arct_pkg.sv
// Register map, field layout and constants of the auto-reload capture timer
package arct_pkg;

    // Byte address width of the register window
    localparam int ADDR_W = 6;
    localparam int DATA_W = 32;
    localparam int BYTE_W = 8;

    // Register byte offsets, one aligned word each
    localparam logic [ADDR_W-1:0] OFS_CTRL = 6'h00;
    localparam logic [ADDR_W-1:0] OFS_CLKCTL = 6'h04;
    localparam logic [ADDR_W-1:0] OFS_IRQEN = 6'h08;
    localparam logic [ADDR_W-1:0] OFS_RELOAD_LO = 6'h0c;
    localparam logic [ADDR_W-1:0] OFS_RELOAD_HI = 6'h10;
    localparam logic [ADDR_W-1:0] OFS_COUNT_LO = 6'h14;
    localparam logic [ADDR_W-1:0] OFS_COUNT_HI = 6'h18;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h1c;
    localparam logic [ADDR_W-1:0] OFS_MASK = 6'h20;

    // Clock control, extended interrupt enable, status and mask bit positions
    localparam int CLK_LOW_FAST_BIT = 0;
    localparam int CLK_HIGH_FAST_BIT = 1;
    localparam int IRQEN_TIMER_BIT = 0;
    localparam int FLAG_HIGH_BIT = 7;
    localparam int FLAG_LOW_BIT = 6;

    // Byte-lane enable that carries every register
    localparam int LANE_LOW = 0;

    // Alternate clock field encodings
    localparam logic [1:0] ALT_DIV12_A = 2'h0;
    localparam logic [1:0] ALT_EXT_DIV8 = 2'h1;
    localparam logic [1:0] ALT_DIV12_B = 2'h2;
    localparam logic [1:0] ALT_COMP = 2'h3;
    localparam int ALT_CAPSRC_BIT = 1;

    // Prescaler ratios
    localparam int SYS_DIV = 12;
    localparam int EXT_DIV = 8;

    // Count values
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [7:0] BYTE_MAX = 8'hff;
    localparam logic [15:0] WORD_MAX = 16'hffff;
    localparam logic [15:0] WORD_ZERO = 16'h0000;

    // Layout of the timer control register
    typedef struct packed {
        logic high_overflow_flag;
        logic low_overflow_flag;
        logic low_overflow_irq_enable;
        logic capture_mode_enable;
        logic split_mode_select;
        logic high_byte_run;
        logic [1:0] alternate_clock_field;
    } arct_ctrl_t;

    // Counting events derived from the slow sources, one cycle each
    typedef struct packed {
        logic div12;
        logic ext_div8;
        logic comp;
    } arct_tick_t;

endpackage

// File: rtl/arct_sync.sv
// Two-flop synchroniser with registered rising-edge detect
module arct_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Asynchronous inputs
    input wire logic [W-1:0] async_in,
    // Synchronised level and one-cycle rising-edge pulse
    output logic [W-1:0] level,
    output logic [W-1:0] rise
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;
    logic [W-1:0] rise_ff;

    // The first stage feeds only the second; metastability settles there
    always_ff @(posedge clk) begin
        if (srst) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rise_ff <= '0;
        end else begin
            rise_ff <= sync_ff & ~level;
        end
    end

    // Delayed copy for the edge detect, updated from the second stage every cycle
    logic [W-1:0] last_ff;
    always_ff @(posedge clk) begin
        if (srst) begin
            last_ff <= '0;
        end else begin
            last_ff <= sync_ff;
        end
    end

    assign level = last_ff;
    assign rise = rise_ff;

endmodule

// File: rtl/arct_timer.sv
// Auto-reload and capture timer with an Avalon-MM register slave
//
// Behaviour
// - Split select clear: both count bytes form one 16-bit auto-reload up-counter.
// - Outside capture mode, 16-bit wrap from all ones loads both reload bytes and sets high flag.
// - Timer interrupt enable and high mask bit set: every 16-bit overflow outside capture mode requests an interrupt.
// - 16-bit mode: low-byte wrap also interrupts when low interrupt enable and low mask bit set.
// - Split select set: two 8-bit timers, each reloading from its own reload byte.
// - Split mode: run bit gates only the high byte; low byte always counts.
// - Fast select picks system clock; else alternate field picks div12, ext/8, comparator.
// - External oscillator and comparator inputs are synchronised before counting.
// - Split mode: each byte wrap sets its own overflow flag.
// - Split mode: high wrap interrupts when timer interrupt enable and high mask bit set; low wrap too when low enable and low mask bit set.
// - Overflow flags never clear by hardware; software clears them.
// - Capture enable selects capture mode on the full 16-bit counter.
// - Capture event on comparator rising edge, or every 8 external clocks.
// - Capture copies count into reload bytes, sets high flag, may interrupt.
// - Set high flag with timer interrupt enable and high mask bit set raises the interrupt.
module arct_timer (
    // Clock and reset
    input wire logic CLK,
    input wire logic SRST,
    // Avalon-MM slave
    input wire logic [arct_pkg::ADDR_W-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [arct_pkg::DATA_W-1:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [arct_pkg::DATA_W-1:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    // Asynchronous count and capture sources
    input wire logic EXT_OSC,
    input wire logic COMP1,
    // Interrupt
    output logic IRQ
);

    // Configuration
    logic low_ien_ff, cap_en_ff, split_ff, run_ff;
    logic [1:0] alt_ff;
    logic fast_lo_ff, fast_hi_ff, tmr_ien_ff, mask_hi_ff, mask_lo_ff;

    // Counter, reload and flags
    logic [7:0] cnt_lo_ff, cnt_hi_ff, rl_lo_ff, rl_hi_ff;
    logic [7:0] nxt_cnt_lo, nxt_cnt_hi;
    logic hf_ff, lf_ff, irq_ff;

    // Bus
    logic ack_ff;
    logic [arct_pkg::DATA_W-1:0] rdata_ff;
    logic [7:0] rd_byte, wdat;
    logic req, wr_fire;
    arct_pkg::arct_ctrl_t wctl;

    // Prescalers and ticks
    logic [3:0] div12_ff;
    logic [2:0] ext_cnt_ff;
    logic ext_rise;
    logic comp_rise;
    arct_pkg::arct_tick_t ticks;
    arct_pkg::arct_ctrl_t ctrl_view;

    // Derived control
    logic wide, lo_tick, hi_tick, count16, lo_inc, hi_inc;
    logic lo_wrap, hi_wrap, cap_evt, hf_set, lf_set;

    function automatic logic hit(input logic [arct_pkg::ADDR_W-1:0] ofs);
        hit = wr_fire && (AVS_ADDRESS == ofs);
    endfunction

    // Source select shared by both count bytes
    function automatic logic sel_tick(input logic fast, input logic [1:0] alt,
                                      input arct_pkg::arct_tick_t t);
        logic r;
        r = 1'b0;
        if (fast) begin
            r = 1'b1;
        end else begin
            unique case (alt)
                arct_pkg::ALT_DIV12_A: r = t.div12;
                arct_pkg::ALT_EXT_DIV8: r = t.ext_div8;
                arct_pkg::ALT_DIV12_B: r = t.div12;
                arct_pkg::ALT_COMP: r = t.comp;
            endcase
        end
        sel_tick = r;
    endfunction

    // ---- Avalon-MM slave: one wait cycle for every access ----
    assign req = AVS_READ | AVS_WRITE;
    assign AVS_WAITREQUEST = req & ~ack_ff;
    assign AVS_READDATA = rdata_ff;
    assign wr_fire = AVS_WRITE & ack_ff & AVS_BYTEENABLE[arct_pkg::LANE_LOW];
    assign wdat = AVS_WRITEDATA[7:0];
    assign wctl = arct_pkg::arct_ctrl_t'(wdat);

    always_ff @(posedge CLK) begin
        if (SRST) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= req & ~ack_ff;
        end
    end

    assign ctrl_view = '{
        high_overflow_flag: hf_ff,
        low_overflow_flag: lf_ff,
        low_overflow_irq_enable: low_ien_ff,
        capture_mode_enable: cap_en_ff,
        split_mode_select: split_ff,
        high_byte_run: run_ff,
        alternate_clock_field: alt_ff
    };

    always_comb begin
        rd_byte = 8'h00;
        unique case (AVS_ADDRESS)
            arct_pkg::OFS_CTRL: rd_byte = ctrl_view;
            arct_pkg::OFS_CLKCTL: begin
                rd_byte[arct_pkg::CLK_LOW_FAST_BIT] = fast_lo_ff;
                rd_byte[arct_pkg::CLK_HIGH_FAST_BIT] = fast_hi_ff;
            end
            arct_pkg::OFS_IRQEN: rd_byte[arct_pkg::IRQEN_TIMER_BIT] = tmr_ien_ff;
            arct_pkg::OFS_RELOAD_LO: rd_byte = rl_lo_ff;
            arct_pkg::OFS_RELOAD_HI: rd_byte = rl_hi_ff;
            arct_pkg::OFS_COUNT_LO: rd_byte = cnt_lo_ff;
            arct_pkg::OFS_COUNT_HI: rd_byte = cnt_hi_ff;
            arct_pkg::OFS_STATUS: begin
                rd_byte[arct_pkg::FLAG_HIGH_BIT] = hf_ff;
                rd_byte[arct_pkg::FLAG_LOW_BIT] = lf_ff;
            end
            arct_pkg::OFS_MASK: begin
                rd_byte[arct_pkg::FLAG_HIGH_BIT] = mask_hi_ff;
                rd_byte[arct_pkg::FLAG_LOW_BIT] = mask_lo_ff;
            end
            default: rd_byte = 8'h00;
        endcase
    end

    // Read data is captured in the wait cycle so it stands when waitrequest drops
    always_ff @(posedge CLK) begin
        if (SRST) begin
            rdata_ff <= '0;
        end else if (AVS_READ && !ack_ff) begin
            rdata_ff <= {{(arct_pkg::DATA_W - arct_pkg::BYTE_W){1'b0}}, rd_byte};
        end
    end

    // ---- Configuration registers ----
    always_ff @(posedge CLK) begin
        if (SRST) begin
            low_ien_ff <= 1'b0;
            cap_en_ff <= 1'b0;
            split_ff <= 1'b0;
            run_ff <= 1'b0;
            alt_ff <= arct_pkg::ALT_DIV12_A;
        end else if (hit(arct_pkg::OFS_CTRL)) begin
            low_ien_ff <= wctl.low_overflow_irq_enable;
            cap_en_ff <= wctl.capture_mode_enable;
            split_ff <= wctl.split_mode_select;
            run_ff <= wctl.high_byte_run;
            alt_ff <= wctl.alternate_clock_field;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            fast_lo_ff <= 1'b0;
            fast_hi_ff <= 1'b0;
        end else if (hit(arct_pkg::OFS_CLKCTL)) begin
            fast_lo_ff <= wdat[arct_pkg::CLK_LOW_FAST_BIT];
            fast_hi_ff <= wdat[arct_pkg::CLK_HIGH_FAST_BIT];
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            tmr_ien_ff <= 1'b0;
        end else if (hit(arct_pkg::OFS_IRQEN)) begin
            tmr_ien_ff <= wdat[arct_pkg::IRQEN_TIMER_BIT];
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            mask_hi_ff <= 1'b0;
            mask_lo_ff <= 1'b0;
        end else if (hit(arct_pkg::OFS_MASK)) begin
            mask_hi_ff <= wdat[arct_pkg::FLAG_HIGH_BIT];
            mask_lo_ff <= wdat[arct_pkg::FLAG_LOW_BIT];
        end
    end

    // ---- Count sources ----
    arct_sync #(
        .W(2)
    ) u_sync (
        .clk(CLK),
        .srst(SRST),
        .async_in({EXT_OSC, COMP1}),
        .level(),
        .rise({ext_rise, comp_rise})
    );

    always_ff @(posedge CLK) begin
        if (SRST) begin
            div12_ff <= 4'h0;
        end else if (div12_ff == 4'(arct_pkg::SYS_DIV - 1)) begin
            div12_ff <= 4'h0;
        end else begin
            div12_ff <= div12_ff + 4'h1;
        end
    end

    // Eight synchronised external edges make one tick; the oscillator must run
    // well below half the system clock or edges are lost
    always_ff @(posedge CLK) begin
        if (SRST) begin
            ext_cnt_ff <= 3'h0;
        end else if (ext_rise) begin
            ext_cnt_ff <= ext_cnt_ff + 3'h1;
        end
    end

    assign ticks.div12 = (div12_ff == 4'(arct_pkg::SYS_DIV - 1));
    assign ticks.ext_div8 = ext_rise && (ext_cnt_ff == 3'(arct_pkg::EXT_DIV - 1));
    assign ticks.comp = comp_rise;

    assign lo_tick = sel_tick(fast_lo_ff, alt_ff, ticks);
    assign hi_tick = sel_tick(fast_hi_ff, alt_ff, ticks);

    // ---- Counting ----
    // Capture forces the 16-bit structure even if split was left set
    assign wide = ~split_ff | cap_en_ff;
    assign count16 = wide & run_ff & lo_tick;
    assign lo_inc = wide ? count16 : lo_tick;
    assign hi_inc = ~wide & run_ff & hi_tick;
    assign lo_wrap = lo_inc && (cnt_lo_ff == arct_pkg::BYTE_MAX);
    assign hi_wrap = wide ? (count16 && ({cnt_hi_ff, cnt_lo_ff} == arct_pkg::WORD_MAX))
                          : (hi_inc && (cnt_hi_ff == arct_pkg::BYTE_MAX));

    // Capture trigger: high alternate bit picks ext/8, otherwise comparator edges
    assign cap_evt = cap_en_ff &
                     (alt_ff[arct_pkg::ALT_CAPSRC_BIT] ? ticks.ext_div8 : ticks.comp);

    always_comb begin
        nxt_cnt_lo = cnt_lo_ff;
        nxt_cnt_hi = cnt_hi_ff;
        if (wide) begin
            if (count16) begin
                if (hi_wrap) begin
                    // Reload bytes hold captures in capture mode, so it free-runs
                    {nxt_cnt_hi, nxt_cnt_lo} = cap_en_ff ? arct_pkg::WORD_ZERO
                                                         : {rl_hi_ff, rl_lo_ff};
                end else begin
                    {nxt_cnt_hi, nxt_cnt_lo} = {cnt_hi_ff, cnt_lo_ff} + 16'h0001;
                end
            end
        end else begin
            if (lo_inc) begin
                nxt_cnt_lo = lo_wrap ? rl_lo_ff : cnt_lo_ff + 8'h01;
            end
            if (hi_inc) begin
                nxt_cnt_hi = hi_wrap ? rl_hi_ff : cnt_hi_ff + 8'h01;
            end
        end
        // A software write to a count byte wins over the tick in the same cycle
        if (hit(arct_pkg::OFS_COUNT_LO)) begin
            nxt_cnt_lo = wdat;
        end
        if (hit(arct_pkg::OFS_COUNT_HI)) begin
            nxt_cnt_hi = wdat;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            cnt_lo_ff <= arct_pkg::BYTE_RST;
            cnt_hi_ff <= arct_pkg::BYTE_RST;
        end else begin
            cnt_lo_ff <= nxt_cnt_lo;
            cnt_hi_ff <= nxt_cnt_hi;
        end
    end

    // Capture wins over a software write to the reload bytes in the same cycle
    always_ff @(posedge CLK) begin
        if (SRST) begin
            rl_lo_ff <= arct_pkg::BYTE_RST;
            rl_hi_ff <= arct_pkg::BYTE_RST;
        end else if (cap_evt) begin
            rl_lo_ff <= cnt_lo_ff;
            rl_hi_ff <= cnt_hi_ff;
        end else begin
            if (hit(arct_pkg::OFS_RELOAD_LO)) begin
                rl_lo_ff <= wdat;
            end
            if (hit(arct_pkg::OFS_RELOAD_HI)) begin
                rl_hi_ff <= wdat;
            end
        end
    end

    // ---- Flags: set by events, cleared only by a one written to status ----
    assign hf_set = (hi_wrap & ~cap_en_ff) | cap_evt;
    assign lf_set = lo_wrap;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            hf_ff <= 1'b0;
            lf_ff <= 1'b0;
        end else begin
            // Set wins over a clear arriving in the same cycle
            hf_ff <= hf_set |
                     (hf_ff & ~(hit(arct_pkg::OFS_STATUS) & wdat[arct_pkg::FLAG_HIGH_BIT]));
            lf_ff <= lf_set |
                     (lf_ff & ~(hit(arct_pkg::OFS_STATUS) & wdat[arct_pkg::FLAG_LOW_BIT]));
        end
    end

    // ---- Interrupt: level while an enabled, unmasked flag is set ----
    always_ff @(posedge CLK) begin
        if (SRST) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= tmr_ien_ff & ((hf_ff & mask_hi_ff) |
                                    (lf_ff & low_ien_ff & mask_lo_ff));
        end
    end

    assign IRQ = irq_ff;

endmodule

// File: tb/arct_timer_sva.sv
// Bus and interrupt checks for the auto-reload capture timer
module arct_timer_sva (
    // Clock and reset
    input wire logic CLK,
    input wire logic SRST,
    // Register bus
    input wire logic [arct_pkg::ADDR_W-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [arct_pkg::DATA_W-1:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    input wire logic [arct_pkg::DATA_W-1:0] AVS_READDATA,
    input wire logic AVS_WAITREQUEST,
    // Sources and interrupt
    input wire logic EXT_OSC,
    input wire logic COMP1,
    input wire logic IRQ
);
    logic wr_acc;
    assign wr_acc = AVS_WRITE & ~AVS_WAITREQUEST;

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SRST);

    sequence req_wait;
        (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
    endsequence
    sequence req_done;
        (AVS_READ || AVS_WRITE) && !AVS_WAITREQUEST;
    endsequence
    sequence rd_seen(logic [arct_pkg::ADDR_W-1:0] a);
        AVS_READ && AVS_WAITREQUEST && AVS_ADDRESS == a;
    endsequence

    one_wait_a: assert property (req_wait ##1 (AVS_READ || AVS_WRITE) |-> !AVS_WAITREQUEST)
        else $error("waitrequest held past one cycle");
    again_wait_a: assert property (req_done ##1 (AVS_READ || AVS_WRITE) |-> AVS_WAITREQUEST)
        else $error("new request got no wait cycle");
    idle_wait_a: assert property (!(AVS_READ || AVS_WRITE) |-> !AVS_WAITREQUEST)
        else $error("waitrequest without request");
    rdata_hold_a: assert property (!AVS_READ |=> $stable(AVS_READDATA))
        else $error("read data moved without read");
    rdata_top_a: assert property (AVS_READDATA[31:8] == 24'h0)
        else $error("read data upper bits set");
    unmapped_zero_a: assert property (AVS_READ && AVS_WAITREQUEST &&
        (AVS_ADDRESS[1:0] != 2'h0 || AVS_ADDRESS > arct_pkg::OFS_MASK) |=> AVS_READDATA == 32'h0)
        else $error("unmapped read not zero");
    status_bits_a: assert property (rd_seen(arct_pkg::OFS_STATUS) |=> AVS_READDATA[5:0] == 6'h0)
        else $error("status spare bits set");
    irqen_bits_a: assert property (rd_seen(arct_pkg::OFS_IRQEN) |=> AVS_READDATA[7:1] == 7'h0)
        else $error("enable spare bits set");
    irq_fall_a: assert property ($fell(IRQ) && !$past(SRST) |-> $past(wr_acc, 2))
        else $error("interrupt dropped without a write");
endmodule

bind arct_timer arct_timer_sva i_sva (
    .CLK, .SRST, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA, .AVS_BYTEENABLE,
    .AVS_READDATA, .AVS_WAITREQUEST, .EXT_OSC, .COMP1, .IRQ
);

// File: tb/arct_timer_tb_top.sv
// Self-checking bench for the auto-reload capture timer
`define CK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
$display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module arct_timer_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [5:0] a;
        logic [7:0] r0;
        logic [3:0] b;
        logic [7:0] d;
        logic [7:0] e;
    } arct_row_t;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [5:0] addr = 6'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] be = 4'h0;
    logic [31:0] rdata;
    logic waitreq;
    logic ext_osc = 1'b0;
    logic comp1 = 1'b0;
    logic irq;
    logic wq_s = 1'b1;
    logic [7:0] rd_s = 8'h00;
    logic [7:0] q;
    int n_fail = 0;
    int num_checks = 0;
    int cyc = 0;
    bit linked = 1'b0;
    logic [7:0] lo_b [4] = '{8'h0f, 8'h02, 8'h0f, 8'h04};
    logic [7:0] hi_b [4] = '{8'h12, 8'h02, 8'h12, 8'h04};
    // Reset value, then write and read back; byte lane 0 low must change nothing
    arct_row_t rows [13] = '{
        '{arct_pkg::OFS_CTRL, 8'h00, 4'h1, 8'he3, 8'h23},
        '{arct_pkg::OFS_CLKCTL, 8'h00, 4'h1, 8'h03, 8'h03},
        '{arct_pkg::OFS_IRQEN, 8'h00, 4'h1, 8'h01, 8'h01},
        '{arct_pkg::OFS_RELOAD_LO, 8'h00, 4'h1, 8'ha5, 8'ha5},
        '{arct_pkg::OFS_RELOAD_HI, 8'h00, 4'h1, 8'h5a, 8'h5a},
        '{arct_pkg::OFS_COUNT_LO, 8'h00, 4'h1, 8'h3c, 8'h3c},
        '{arct_pkg::OFS_COUNT_HI, 8'h00, 4'h1, 8'hc3, 8'hc3},
        '{arct_pkg::OFS_STATUS, 8'h00, 4'h1, 8'hc0, 8'h00},
        '{arct_pkg::OFS_MASK, 8'h00, 4'h1, 8'hc0, 8'hc0},
        '{arct_pkg::OFS_CTRL, 8'h23, 4'h0, 8'h00, 8'h23},
        '{6'h24, 8'h00, 4'h1, 8'hff, 8'h00},
        '{6'h01, 8'h00, 4'h1, 8'hff, 8'h00},
        '{6'h3c, 8'h00, 4'h1, 8'hff, 8'h00}};

    arct_timer i_dut (.CLK(clk), .SRST(srst), .AVS_ADDRESS(addr), .AVS_READ(rd),
        .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
        .AVS_WAITREQUEST(waitreq), .EXT_OSC(ext_osc), .COMP1(comp1), .IRQ(irq));

    initial begin
        forever #20 clk = ~clk;
    end

    // Mid-cycle snapshots keep the bus sampling free of edge races
    always @(negedge clk) begin
        wq_s <= waitreq;
        rd_s <= rdata[7:0];
    end

    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Whole run is about 1400 cycles; reaching 20000 cycles means a hang
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            close_out;
        end
    end

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask
    // A kept request leaves the strobe up so the next call follows with no gap
    task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] d,
                        input logic [3:0] b, input bit keep = 1'b0);
        if (!linked) @(posedge clk);
        addr <= a;
        wdata <= {24'h0, d};
        be <= b;
        wr <= w;
        rd <= ~w;
        do @(posedge clk); while (wq_s !== 1'b0);
        q = rd_s;
        linked = keep;
        if (!keep) begin
            wr <= 1'b0;
            rd <= 1'b0;
        end
    endtask
    task automatic wrt(input logic [5:0] a, input logic [7:0] d);
        xfer(1'b1, a, d, 4'h1);
    endtask
    task automatic rdc(input logic [5:0] a, input logic [7:0] e);
        xfer(1'b0, a, 8'h00, 4'h1);
        `CK(q, e)
    endtask
    task automatic pair(input logic [5:0] a, input logic [7:0] lo, input logic [7:0] hi);
        xfer(1'b1, a, lo, 4'h1, 1'b1);
        wrt(a + 6'h04, hi);
    endtask
    task automatic irqc(input logic e);
        @(negedge clk);
        `CK(irq, e)
    endtask
    task automatic src(input int n, input logic e, input logic c);
        for (int i = 0; i < n; i++) begin
            ext_osc <= e;
            comp1 <= c && (i % 4 == 0);
            idle(6);
            ext_osc <= 1'b0;
            comp1 <= 1'b0;
            idle(6);
        end
    endtask
    task automatic done(input string s);
        $display("test %s finished", s);
    endtask

    initial begin
        idle(5);
        srst <= 1'b0;
        foreach (rows[k]) begin
            rdc(rows[k].a, rows[k].r0);
            xfer(1'b1, rows[k].a, rows[k].d, rows[k].b);
            rdc(rows[k].a, rows[k].e);
        end
        done("registers");
        pair(arct_pkg::OFS_RELOAD_LO, 8'h34, 8'h12);
        wrt(arct_pkg::OFS_CLKCTL, 8'h01);
        wrt(arct_pkg::OFS_MASK, 8'h80);
        pair(arct_pkg::OFS_COUNT_LO, 8'hfe, 8'hff);
        wrt(arct_pkg::OFS_CTRL, 8'h04);
        idle(4);
        wrt(arct_pkg::OFS_CTRL, 8'h00);
        rdc(arct_pkg::OFS_COUNT_HI, 8'h12);
        rdc(arct_pkg::OFS_STATUS, 8'hc0);
        irqc(1'b1);
        idle(30);
        rdc(arct_pkg::OFS_STATUS, 8'hc0);
        wrt(arct_pkg::OFS_STATUS, 8'h80);
        rdc(arct_pkg::OFS_STATUS, 8'h40);
        irqc(1'b0);
        wrt(arct_pkg::OFS_MASK, 8'h40);
        idle(2);
        irqc(1'b0);
        wrt(arct_pkg::OFS_CTRL, 8'h20);
        idle(2);
        irqc(1'b1);
        done("wide");
        wrt(arct_pkg::OFS_STATUS, 8'hc0);
        pair(arct_pkg::OFS_RELOAD_LO, 8'hf0, 8'h80);
        pair(arct_pkg::OFS_COUNT_LO, 8'hfe, 8'hfe);
        wrt(arct_pkg::OFS_CLKCTL, 8'h03);
        wrt(arct_pkg::OFS_MASK, 8'hc0);
        wrt(arct_pkg::OFS_CTRL, 8'h08);
        idle(20);
        irqc(1'b0);
        rdc(arct_pkg::OFS_COUNT_HI, 8'hfe);
        xfer(1'b0, arct_pkg::OFS_COUNT_LO, 8'h00, 4'h1);
        `CK(q inside {[8'hf0:8'hff]}, 1'b1)
        rdc(arct_pkg::OFS_STATUS, 8'h40);
        wrt(arct_pkg::OFS_CTRL, 8'h0c);
        idle(4);
        wrt(arct_pkg::OFS_CTRL, 8'h00);
        xfer(1'b0, arct_pkg::OFS_COUNT_HI, 8'h00, 4'h1);
        `CK(q inside {[8'h80:8'h8f]}, 1'b1)
        rdc(arct_pkg::OFS_STATUS, 8'hc0);
        irqc(1'b1);
        done("split");
        wrt(arct_pkg::OFS_CLKCTL, 8'h00);
        for (int k = 0; k < 4; k++) begin
            pair(arct_pkg::OFS_COUNT_LO, 8'h00, 8'h00);
            wrt(arct_pkg::OFS_CTRL, {6'h01, k[1:0]});
            src(16, 1'b1, 1'b1);
            idle(8);
            wrt(arct_pkg::OFS_CTRL, 8'h00);
            xfer(1'b0, arct_pkg::OFS_COUNT_LO, 8'h00, 4'h1);
            `CK(q inside {[lo_b[k]:hi_b[k]]}, 1'b1)
        end
        done("sources");
        wrt(arct_pkg::OFS_CLKCTL, 8'h01);
        pair(arct_pkg::OFS_COUNT_LO, 8'h00, 8'h00);
        pair(arct_pkg::OFS_RELOAD_LO, 8'h00, 8'h00);
        wrt(arct_pkg::OFS_STATUS, 8'hc0);
        wrt(arct_pkg::OFS_CTRL, 8'h16);
        src(4, 1'b0, 1'b1);
        idle(6);
        rdc(arct_pkg::OFS_STATUS, 8'h00);
        src(8, 1'b1, 1'b0);
        idle(6);
        rdc(arct_pkg::OFS_STATUS, 8'h80);
        irqc(1'b1);
        rdc(arct_pkg::OFS_RELOAD_HI, 8'h00);
        xfer(1'b0, arct_pkg::OFS_RELOAD_LO, 8'h00, 4'h1);
        `CK(q inside {[8'h64:8'hfa]}, 1'b1)
        wrt(arct_pkg::OFS_STATUS, 8'h80);
        wrt(arct_pkg::OFS_CTRL, 8'h14);
        src(4, 1'b0, 1'b1);
        idle(6);
        xfer(1'b0, arct_pkg::OFS_STATUS, 8'h00, 4'h1);
        `CK(q[7], 1'b1)
        done("capture");
        srst <= 1'b1;
        idle(5);
        srst <= 1'b0;
        rdc(arct_pkg::OFS_CTRL, 8'h00);
        rdc(arct_pkg::OFS_COUNT_LO, 8'h00);
        rdc(arct_pkg::OFS_RELOAD_LO, 8'h00);
        irqc(1'b0);
        done("reset");
        close_out;
    end
endmodule
